/* dv/tb_top.sv */
// self-checking bench of the timing generator divider
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tgd_pkg::*;
   logic       mclk, arst_n, high_freq_tick, low_freq_tick;
   logic       hi_on, hi_alt, lo_run, lo_pulse;
   tgd_mode_t  mode;
   logic       dual_clock_mode, system_clock_select, seventh_stage_source_select;
   logic       warmup_active, instr_start;
   logic [3:0] instr_len;
   logic       main_clk_en, divider_pulse_output, time_base_timer_clk;
   logic       warmup_clk, mc_end, instr_done;
   logic [20:0] divider_taps;
   tgd_state_t mc_state;
   int         errors, n_compared, g, base;

   tgd_timing_gen tgd_timing_gen_inst (
      .mclk(mclk), .arst_n(arst_n), .high_freq_tick(high_freq_tick),
      .low_freq_tick(low_freq_tick), .mode(mode), .dual_clock_mode(dual_clock_mode),
      .system_clock_select(system_clock_select),
      .seventh_stage_source_select(seventh_stage_source_select),
      .warmup_active(warmup_active), .instr_start(instr_start), .instr_len(instr_len),
      .main_clk_en(main_clk_en), .divider_taps(divider_taps),
      .divider_pulse_output(divider_pulse_output),
      .time_base_timer_clk(time_base_timer_clk), .warmup_clk(warmup_clk),
      .mc_state(mc_state), .mc_end(mc_end), .instr_done(instr_done));

   // ***********************
   // clock and tick sources
   // ***********************
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      high_freq_tick <= hi_alt ? ~high_freq_tick : hi_on;
      low_freq_tick  <= lo_run ? ~low_freq_tick : lo_pulse;
   end

   // ***********************
   // helpers
   // ***********************
   task automatic chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic cyc(input int n = 1);
      repeat (n) begin
         @(posedge mclk);
         #1;
      end
   endtask : cyc
   task automatic setup(input tgd_mode_t m, input logic d, input logic s, input logic v,
                        input logic h, input logic l);
      @(posedge mclk);
      mode <= m;
      dual_clock_mode <= d;
      system_clock_select <= s;
      seventh_stage_source_select <= v;
      hi_on <= h;
      lo_run <= l;
      cyc(3);
   endtask : setup
   function automatic logic sig(input int k);
      return (k < 21) ? divider_taps[k] : mc_end;
   endfunction : sig
   // cycles between two rising edges of a tap, or of mc_end for k = 21
   task automatic rise_gap(input int k, output int gap);
      int t;
      for (t = 0; t < 3000 && sig(k) !== 1'b0; t++) cyc();
      for (t = 0; t < 3000 && sig(k) !== 1'b1; t++) cyc();
      gap = 0;
      do begin
         cyc();
         gap++;
      end while (gap < 3000 && sig(k) === 1'b1);
      while (gap < 3000 && sig(k) !== 1'b1) begin
         cyc();
         gap++;
      end
   endtask : rise_gap
   task automatic run_instr(input logic [3:0] len, output int n);
      int t;
      for (t = 0; t < 100 && mc_state !== TGD_S3; t++) cyc();
      @(posedge mclk);
      instr_start <= 1'b1;
      instr_len <= len;
      @(posedge mclk);
      instr_start <= 1'b0;
      #1;
      for (n = 1; n < 100 && instr_done !== 1'b1; n++) cyc();
      cyc();
      chk(instr_done === 1'b0, "done wider than one cycle");
   endtask : run_instr

   // ***********************
   // scenarios
   // ***********************
   task automatic t_cycle();
      setup(TGD_NORMAL, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      rise_gap(21, g);
      chk(g === 4, "machine cycle length");
      for (int k = 0; k < 5; k++) begin
         rise_gap(k, g);
         chk(g === (8 << k), "tap period");
      end
      hi_alt <= 1'b1;
      rise_gap(21, g);
      chk(g === 8, "four high periods per cycle");
      hi_alt <= 1'b0;
      $display("test cycle done");
   endtask : t_cycle
   task automatic t_instr();
      logic [3:0] lens [5] = '{4'h1, 4'h2, 4'hA, 4'hF, 4'h0};
      int         exp  [5] = '{1, 2, 10, 10, 1};
      for (int i = 0; i < 5; i++) begin
         run_instr(lens[i], g);
         if (i == 0) base = g;
         chk(g - base === 4 * (exp[i] - 1), "instruction length");
      end
      $display("test instr done");
   endtask : t_instr
   task automatic t_stop_warm();
      lo_run <= 1'b1;
      cyc(20);
      chk(divider_taps !== 21'h00_0000, "divider not running");
      setup(TGD_STOP, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      chk(divider_taps === 21'h00_0000 && mc_state === TGD_S0, "stop clear");
      @(posedge mclk);
      warmup_active <= 1'b1;
      mode <= TGD_NORMAL;
      hi_on <= 1'b1;
      for (g = 0; g < 400 && divider_taps[6] !== 1'b1; g++) cyc();
      chk(g >= 250 && g <= 265, "warm-up stage seven source");
      warmup_active <= 1'b0;
      $display("test stop done");
   endtask : t_stop_warm
   task automatic t_low();
      logic [5:0] snap;
      for (int i = 0; i < 4; i++) begin
         setup(i < 2 ? TGD_SLOW : TGD_SLEEP, 1'b1, 1'b1, i[0], 1'b1, 1'b1);
         snap = divider_taps[5:0];
         rise_gap(6, g);
         chk(g === 4, "low clock into stage seven");
         chk(divider_taps[5:0] === snap, "stages one to six stopped");
      end
      setup(TGD_NORMAL, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      rise_gap(6, g);
      chk(g === 4, "select picks low clock");
      setup(TGD_NORMAL, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      snap = divider_taps[6:1];
      cyc(40);
      chk(divider_taps[6:1] === snap, "select off ignores low clock");
      $display("test low done");
   endtask : t_low
   task automatic t_sysclk();
      setup(TGD_NORMAL, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      chk(main_clk_en === 1'b0, "main clock still high source");
      @(posedge mclk);
      lo_pulse <= 1'b1;
      @(posedge mclk);
      lo_pulse <= 1'b0;
      for (g = 0; g < 4 && main_clk_en !== 1'b1; g++) cyc();
      chk(g < 4, "main clock from low tick");
      setup(TGD_NORMAL, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      chk(main_clk_en === 1'b1, "main clock from high tick");
      $display("test sysclk done");
   endtask : t_sysclk
   task automatic t_tbt();
      setup(TGD_SLOW, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      @(posedge mclk);
      lo_pulse <= 1'b1;
      warmup_active <= 1'b1;
      cyc();
      for (g = 0; g < 600 && divider_pulse_output !== 1'b1; g++) cyc();
      chk(g < 600 && divider_taps[13] === 1'b1, "divider pulse from stage fourteen");
      for (g = 0; g < 33000 && time_base_timer_clk !== 1'b1; g++) cyc();
      chk(g < 33000 && warmup_clk === 1'b1, "time base and warm-up clocks");
      cyc();
      chk({time_base_timer_clk, warmup_clk} === 2'b00, "time base pulse one cycle");
      {lo_pulse, warmup_active} <= 2'b00;
      $display("test tbt done");
   endtask : t_tbt

   // ***********************
   // run control
   // ***********************
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   initial begin
      #1500us;
      errors++;
      end_of_test();
   end
   initial begin
      {arst_n, hi_on, hi_alt, lo_run, lo_pulse, instr_start} = '0;
      {dual_clock_mode, system_clock_select, seventh_stage_source_select} = '0;
      {high_freq_tick, low_freq_tick, warmup_active, errors, n_compared} = '0;
      mode = TGD_NORMAL;
      instr_len = 4'h1;
      cyc(8);
      chk(divider_taps === 21'h00_0000 && mc_state === TGD_S0, "reset state");
      chk({main_clk_en, mc_end, instr_done, divider_pulse_output} === 4'h0, "reset out");
      @(posedge mclk);
      arst_n <= 1'b1;
      t_cycle();
      t_instr();
      t_stop_warm();
      t_low();
      t_sysclk();
      t_tbt();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire

/* src/tgd_pkg.sv */
// constants and types of the timing generator divider
//
// What this block does
// - two-stage prescaler then twenty-one-stage divider chain
// - reset and stop entry/exit clear all stages
// - stage seven source from mode and select bits
// - slow and sleep modes feed low clock
// - warm-up after stop from normal uses stage six
// - machine cycle is four states, one clock each
// - instructions last one to ten machine cycles
// - all outputs synchronized to main system clock
// - high clock: one machine cycle per four periods
// - low-only modes stop stages one to six
// - system clock select one picks low clock
`default_nettype none
package tgd_pkg;
   localparam int PRESC_STAGES = 2;
   localparam int DIV_STAGES   = 21;
   localparam int SEVEN_IDX    = 6;   // zero-based index of stage seven
   localparam int SIX_IDX      = 5;
   localparam int DVO_IDX      = 13;  // divider pulse tap: stage fourteen, free choice
   localparam int STATES_PER_MC = 4;
   localparam int MAX_MC_LEN   = 10;
   localparam logic [3:0] MC_LEN_MIN = 4'h1;
   localparam logic [3:0] MC_LEN_MAX = 4'hA;
   localparam logic [DIV_STAGES-1:0] DIV_RESET = 21'h00_0000;
   localparam logic [PRESC_STAGES-1:0] PRESC_RESET = 2'h0;

   // operating mode, gray along normal -> idle -> slow -> sleep -> stop
   typedef enum logic [2:0] {
      TGD_NORMAL = 3'b000,
      TGD_IDLE   = 3'b001,
      TGD_SLOW   = 3'b011,
      TGD_SLEEP  = 3'b010,
      TGD_STOP   = 3'b110
   } tgd_mode_t;

   // machine cycle states, gray coded
   typedef enum logic [1:0] {
      TGD_S0 = 2'b00,
      TGD_S1 = 2'b01,
      TGD_S2 = 2'b11,
      TGD_S3 = 2'b10
   } tgd_state_t;
endpackage : tgd_pkg
`default_nettype wire

/* src/tgd_stage.sv */
// one halving divider stage driven by an enable
`default_nettype none
module tgd_stage (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic clr,
   input  wire logic en_in,
   output logic      q,
   output logic      en_out
);
   logic q_ff;
   logic nxt_q;

   // toggle on enable; carry out on falling edge of the stage output
   always_comb begin
      nxt_q = q_ff;
      if (clr) begin
         nxt_q = 1'b0;
      end else if (en_in) begin
         nxt_q = ~q_ff;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q_ff <= 1'b0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign q      = q_ff;
   assign en_out = en_in & q_ff & ~clr;
endmodule : tgd_stage
`default_nettype wire

/* src/tgd_timing_gen.sv */
// timing generator: prescaler, divider chain, machine cycle counter
`default_nettype none
module tgd_timing_gen
   import tgd_pkg::*;
#(
   parameter int DIV_N = tgd_pkg::DIV_STAGES
) (
   input  wire logic                  mclk,
   input  wire logic                  arst_n,
   input  wire logic                  high_freq_tick,
   input  wire logic                  low_freq_tick,
   input  wire tgd_pkg::tgd_mode_t    mode,
   input  wire logic                  dual_clock_mode,
   input  wire logic                  system_clock_select,
   input  wire logic                  seventh_stage_source_select,
   input  wire logic                  warmup_active,
   input  wire logic                  instr_start,
   input  wire logic [3:0]            instr_len,
   output logic                       main_clk_en,
   output logic [DIV_N-1:0]           divider_taps,
   output logic                       divider_pulse_output,
   output logic                       time_base_timer_clk,
   output logic                       warmup_clk,
   output tgd_pkg::tgd_state_t        mc_state,
   output logic                       mc_end,
   output logic                       instr_done
);
   import tgd_pkg::*;

   // ***************************
   // stop transition detect
   // ***************************
   logic stop_ff;
   logic from_normal_ff;
   logic nxt_from_normal;
   logic stop_edge;
   logic low_only;
   logic sel7_low;

   assign stop_edge = (mode == TGD_STOP) ^ stop_ff;
   assign low_only  = (mode == TGD_SLOW) || (mode == TGD_SLEEP);

   always_comb begin
      nxt_from_normal = from_normal_ff;
      if ((mode == TGD_STOP) && !stop_ff) begin
         nxt_from_normal = ~system_clock_select;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         stop_ff        <= 1'b0;
         from_normal_ff <= 1'b0;
      end else begin
         stop_ff        <= (mode == TGD_STOP);
         from_normal_ff <= nxt_from_normal;
      end
   end

   // ***************************
   // prescaler and divider chain
   // ***************************
   logic [PRESC_STAGES-1:0] pre_ff;
   logic [PRESC_STAGES-1:0] nxt_pre;
   logic                    pre_en;
   logic                    hf_run;
   logic [DIV_N:0]          en_chain;
   logic [DIV_N-1:0]        div_q;
   logic                    en7;

   assign hf_run = high_freq_tick && !low_only && (mode != TGD_STOP);

   always_comb begin
      nxt_pre = pre_ff;
      if (stop_edge) begin
         nxt_pre = PRESC_RESET;
      end else if (hf_run) begin
         nxt_pre = pre_ff + 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pre_ff <= PRESC_RESET;
      end else begin
         pre_ff <= nxt_pre;
      end
   end

   assign pre_en = hf_run && (pre_ff == {PRESC_STAGES{1'b1}});

   // stage seven source selection
   always_comb begin
      sel7_low = 1'b0;
      if (low_only) begin
         sel7_low = 1'b1;
      end else if (warmup_active && from_normal_ff) begin
         sel7_low = 1'b0;
      end else begin
         sel7_low = seventh_stage_source_select && dual_clock_mode;
      end
   end

   assign en7 = sel7_low ? (low_freq_tick && (mode != TGD_STOP)) : en_chain[SEVEN_IDX];

   genvar g;
   generate
      for (g = 0; g < DIV_N; g++) begin : g_div
         logic ein;
         if (g == 0) begin : g_first
            assign ein = pre_en;
         end else if (g == SEVEN_IDX) begin : g_seven
            assign ein = en7;
         end else begin : g_rest
            assign ein = en_chain[g];
         end
         tgd_stage u_stage (
            .mclk   (mclk),
            .arst_n (arst_n),
            .clr    (stop_edge),
            .en_in  (ein),
            .q      (div_q[g]),
            .en_out (en_chain[g+1])
         );
      end
   endgenerate
   assign en_chain[0] = pre_en;

   // ***************************
   // main clock and machine cycle
   // ***************************
   logic       main_en;
   tgd_state_t st_ff;
   tgd_state_t nxt_st;
   logic [3:0] mc_cnt_ff;
   logic [3:0] nxt_mc_cnt;
   logic       done_ff;
   logic       nxt_done;
   logic       mce_ff;
   logic       nxt_mce;
   logic       men_ff;
   logic [DIV_N-1:0] taps_ff;
   logic       dvo_ff;
   logic       tbt_ff;
   logic       wu_ff;

   // high clock: state per fc period -> 4/fc per cycle; low: per fs
   assign main_en = (mode == TGD_STOP) ? 1'b0 :
                    (system_clock_select || low_only) ? low_freq_tick
                                                      : high_freq_tick;

   always_comb begin
      nxt_st     = st_ff;
      nxt_mc_cnt = mc_cnt_ff;
      nxt_done   = 1'b0;
      nxt_mce    = 1'b0;
      if (stop_edge) begin
         nxt_st     = TGD_S0;
         nxt_mc_cnt = 4'h0;
      end else if (main_en) begin
         case (st_ff)
            TGD_S0: nxt_st = TGD_S1;
            TGD_S1: nxt_st = TGD_S2;
            TGD_S2: nxt_st = TGD_S3;
            TGD_S3: begin
               nxt_st  = TGD_S0;
               nxt_mce = 1'b1;
               if (mc_cnt_ff > 4'h1) begin
                  nxt_mc_cnt = mc_cnt_ff - 4'h1;
               end else if (mc_cnt_ff == 4'h1) begin
                  nxt_mc_cnt = 4'h0;
                  nxt_done   = 1'b1;
               end
            end
            default: nxt_st = TGD_S0;
         endcase
         if ((st_ff == TGD_S0) && instr_start && (mc_cnt_ff == 4'h0)) begin
            if (instr_len < MC_LEN_MIN) begin
               nxt_mc_cnt = MC_LEN_MIN;
            end else if (instr_len > MC_LEN_MAX) begin
               nxt_mc_cnt = MC_LEN_MAX;
            end else begin
               nxt_mc_cnt = instr_len;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff     <= TGD_S0;
         mc_cnt_ff <= 4'h0;
         done_ff   <= 1'b0;
         mce_ff    <= 1'b0;
         men_ff    <= 1'b0;
         taps_ff   <= DIV_RESET;
         dvo_ff    <= 1'b0;
         tbt_ff    <= 1'b0;
         wu_ff     <= 1'b0;
      end else begin
         st_ff     <= nxt_st;
         mc_cnt_ff <= nxt_mc_cnt;
         done_ff   <= nxt_done;
         mce_ff    <= nxt_mce;
         men_ff    <= main_en;
         taps_ff   <= div_q;
         dvo_ff    <= div_q[DVO_IDX];
         tbt_ff    <= en_chain[DIV_N];
         wu_ff     <= en_chain[DIV_N] && warmup_active;
      end
   end

   assign main_clk_en          = men_ff;
   assign divider_taps         = taps_ff;
   assign divider_pulse_output = dvo_ff;
   assign time_base_timer_clk  = tbt_ff;
   assign warmup_clk           = wu_ff;
   assign mc_state             = st_ff;
   assign mc_end               = mce_ff;
   assign instr_done           = done_ff;

   // ***************************
   // assertions
   // ***************************
   a_stop_clears_div : assert property (@(posedge mclk) disable iff (!arst_n)
      stop_edge |=> (div_q == DIV_RESET) && (pre_ff == PRESC_RESET))
      else $error("divider not cleared on stop transition");
   a_low_halts_low : assert property (@(posedge mclk) disable iff (!arst_n)
      low_only && $past(low_only) && !stop_edge |=> $stable(div_q[SIX_IDX:0]))
      else $error("low stages toggled in low-only mode");
   a_slow_feeds_low : assert property (@(posedge mclk) disable iff (!arst_n)
      low_only && low_freq_tick && !stop_edge |=>
      div_q[SEVEN_IDX] != $past(div_q[SEVEN_IDX]))
      else $error("stage seven not on low clock");
   a_warm_stage_six : assert property (@(posedge mclk) disable iff (!arst_n)
      warmup_active && from_normal_ff && !low_only && !stop_edge && !en_chain[SEVEN_IDX]
      |=> $stable(div_q[SEVEN_IDX]))
      else $error("warm-up not driven from stage six");
   a_sel_single : assert property (@(posedge mclk) disable iff (!arst_n)
      !low_only && !warmup_active && !dual_clock_mode && !stop_edge && !en_chain[SEVEN_IDX]
      |=> $stable(div_q[SEVEN_IDX]))
      else $error("low clock selected in single-clock mode");
   a_state_order : assert property (@(posedge mclk) disable iff (!arst_n)
      main_en && !stop_edge && st_ff == TGD_S3 |=> st_ff == TGD_S0 && mce_ff)
      else $error("machine cycle not four states");
   a_len_bound : assert property (@(posedge mclk) disable iff (!arst_n)
      mc_cnt_ff <= MC_LEN_MAX)
      else $error("instruction length above ten");
   a_main_src : assert property (@(posedge mclk) disable iff (!arst_n)
      system_clock_select && mode != TGD_STOP |=> main_clk_en == $past(low_freq_tick))
      else $error("main clock not from low clock");
   a_prescale : assert property (@(posedge mclk) disable iff (!arst_n)
      pre_en && !stop_edge |=> div_q[0] != $past(div_q[0]))
      else $error("prescaler carry wrong");
   c_mc_done   : cover property (@(posedge mclk) done_ff);
   c_stop_in   : cover property (@(posedge mclk) stop_edge && mode == TGD_STOP);
   c_slow_run  : cover property (@(posedge mclk) low_only && en7);
   c_warm      : cover property (@(posedge mclk) warmup_active && from_normal_ff && en7);
endmodule : tgd_timing_gen
`default_nettype wire
